// ### ssp_card_model.sv
// behavioural card standing in the socket
module ssp_card_model (
	input wire logic clk_i,
	input wire logic seat_i,
	input wire logic [3:0] misc_i,
	output logic [5:0] pins_o
);
	// ****************************************
	// pins: ready, protect, detect b/a (low), battery two/one
	// ****************************************
	initial pins_o = 6'h0C;
	// empty socket: detect pins pulled high, the rest pulled low
	always @(posedge clk_i) begin
		pins_o <= seat_i ? {misc_i[3:2], 2'h0, misc_i[1:0]} : 6'h0C;
	end
endmodule

// ### ssp_pin_if.sv
// carries card pins from the synchroniser to the register block
interface ssp_pin_if #(
	parameter int W = 6
);
	logic [W-1:0] raw;
	logic [W-1:0] synced;

	modport sync_side (
		input raw,
		output synced
	);

	modport user_side (
		output raw,
		input synced
	);
endinterface

// ### ssp_pin_sync.sv
// two-stage synchroniser for the asynchronous card pins
module ssp_pin_sync #(
	parameter int W = 6
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	ssp_pin_if.sync_side pins
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} ssp_sync_state_t;

	ssp_sync_state_t state_q;
	ssp_sync_state_t state_d;

	// first stage feeds only the second stage
	always_comb begin
		state_d = state_q;
		state_d.first = pins.raw;
		state_d.second = state_q.first;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign pins.synced = state_q.second;

endmodule

// ### ssp_pkg.sv
// constants shared by the socket status and power control block
package ssp_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_IDENT = 8'h00;
	localparam logic [7:0] OFF_SOCKET_INTERFACE_STATUS = 8'h01;
	localparam logic [7:0] OFF_SOCKET_POWER_CONTROL = 8'h02;

	// ****************************************
	// identification register
	// ****************************************
	localparam logic [1:0] IDENT_TYPE_VALUE = 2'h2;
	localparam logic [1:0] IDENT_RSVD_RESET = 2'h0;
	localparam logic [3:0] COMPAT_REV_RESET = 4'h4;
	localparam logic [3:0] COMPAT_REV_LAYOUT_A = 4'h2;
	localparam int IDENT_TYPE_POS = 6;
	localparam int IDENT_RSVD_POS = 4;

	// ****************************************
	// interface status fields
	// ****************************************
	localparam int ST_POWER_POS = 6;
	localparam int ST_READY_POS = 5;
	localparam int ST_WP_POS = 4;
	localparam int ST_DETECT_B_POS = 3;
	localparam int ST_DETECT_A_POS = 2;
	localparam int ST_BATTERY_TWO_POS = 1;
	localparam int ST_BATTERY_ONE_POS = 0;

	// ****************************************
	// power control fields
	// ****************************************
	localparam int PC_GATE_POS = 7;
	localparam int PC_AUTO_POS = 5;
	localparam int PC_SUPPLY_ON_POS = 4;
	localparam int PC_VCC_HI_POS = 4;
	localparam int PC_VCC_LO_POS = 3;
	localparam int PC_VPP_POS = 0;
	localparam logic [7:0] PC_RESET = 8'h00;
	localparam logic [7:0] PC_MASK_LAYOUT_A = 8'hB3;
	localparam logic [7:0] PC_MASK_LAYOUT_B = 8'h9B;

	// ****************************************
	// voltage codes
	// ****************************************
	localparam logic [1:0] VPP_NONE = 2'h0;
	localparam logic [1:0] VPP_SUPPLY = 2'h1;
	localparam logic [1:0] VPP_12V = 2'h2;
	localparam logic [1:0] VCC_5V = 2'h2;
	localparam logic [1:0] VCC_3V = 2'h3;

	// ****************************************
	// pin synchroniser
	// ****************************************
	localparam int PIN_COUNT = 6;
	localparam logic [PIN_COUNT-1:0] PIN_RESET = 6'h00;

endpackage

// ### ssp_socket_regs.sv
// socket interface status and power control registers
//
// Design decision made here: the strobed register port.
module ssp_socket_regs (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [ssp_pkg::ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic card_ready_i,
	input wire logic write_protect_i,
	input wire logic detect_pin_a_n_i,
	input wire logic detect_pin_b_n_i,
	input wire logic battery_pin_one_i,
	input wire logic battery_pin_two_i,
	input wire logic sys_auto_switch_allow_i,
	input wire logic sys_supply_allow_i,
	output logic card_output_gate_o,
	output logic socket_supply_on_o,
	output logic supply_3v_sel_o,
	output logic [1:0] program_voltage_o,
	output logic socket_power_on_flag_o,
	output logic layout_a_o
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0] rdata;
		logic [1:0] ident_rsvd;
		logic [3:0] compat_revision_field;
		logic card_output_gate;
		logic auto_power_switch_on;
		logic ctrl_bit4;
		logic ctrl_bit3;
		logic [1:0] program_voltage_request;
		logic out_gate;
		logic out_supply;
		logic out_3v;
		logic [1:0] out_vpp;
		logic out_power;
		logic out_layout_a;
	} ssp_state_t;

	ssp_state_t state_q;
	ssp_state_t state_d;

	// ****************************************
	// decoding helpers
	// ****************************************
	function automatic logic is_layout_a(input logic [3:0] rev);
		is_layout_a = (rev == ssp_pkg::COMPAT_REV_LAYOUT_A);
	endfunction

	function automatic logic [1:0] vpp_effective(input logic supply_on, input logic [1:0] req);
		logic [1:0] code;
		code = ssp_pkg::VPP_NONE;
		if (supply_on) begin
			case (req)
				ssp_pkg::VPP_SUPPLY: code = ssp_pkg::VPP_SUPPLY;
				ssp_pkg::VPP_12V: code = ssp_pkg::VPP_12V;
				default: code = ssp_pkg::VPP_NONE;
			endcase
		end
		vpp_effective = code;
	endfunction

	// ****************************************
	// pin synchroniser
	// ****************************************
	ssp_pin_if #(.W(ssp_pkg::PIN_COUNT)) pin_bus ();

	assign pin_bus.raw = {card_ready_i, write_protect_i, detect_pin_b_n_i,
		detect_pin_a_n_i, battery_pin_two_i, battery_pin_one_i};

	ssp_pin_sync #(
		.W(ssp_pkg::PIN_COUNT)
	) u_pin_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.pins(pin_bus.sync_side)
	);

	logic ready_s;
	logic wp_s;
	logic detect_b_n_s;
	logic detect_a_n_s;
	logic battery_two_s;
	logic battery_one_s;

	assign ready_s = pin_bus.synced[5];
	assign wp_s = pin_bus.synced[4];
	assign detect_b_n_s = pin_bus.synced[3];
	assign detect_a_n_s = pin_bus.synced[2];
	assign battery_two_s = pin_bus.synced[1];
	assign battery_one_s = pin_bus.synced[0];

	// ****************************************
	// power evaluation
	// ****************************************
	logic layout_a;
	logic card_seated;
	logic auto_active;
	logic supply_on;
	logic supply_3v;
	logic [1:0] vpp_now;

	always_comb begin
		layout_a = is_layout_a(state_q.compat_revision_field);
		card_seated = !detect_a_n_s && !detect_b_n_s;
		auto_active = state_q.auto_power_switch_on && sys_auto_switch_allow_i;
		supply_on = 1'b0;
		supply_3v = 1'b0;
		if (layout_a) begin
			if (state_q.ctrl_bit4 && sys_supply_allow_i) begin
				supply_on = auto_active ? card_seated : 1'b1;
			end
		end else begin
			case ({state_q.ctrl_bit4, state_q.ctrl_bit3})
				ssp_pkg::VCC_5V: supply_on = 1'b1;
				ssp_pkg::VCC_3V: begin
					supply_on = 1'b1;
					supply_3v = 1'b1;
				end
				default: supply_on = 1'b0;
			endcase
		end
		vpp_now = vpp_effective(supply_on, state_q.program_voltage_request);
	end

	// ****************************************
	// register read values
	// ****************************************
	logic [7:0] status_value;
	logic [7:0] ident_value;
	logic [7:0] ctrl_raw;
	logic [7:0] ctrl_value;

	always_comb begin
		status_value = 8'h00;
		status_value[ssp_pkg::ST_POWER_POS] = state_q.out_power;
		status_value[ssp_pkg::ST_READY_POS] = ready_s;
		status_value[ssp_pkg::ST_WP_POS] = wp_s;
		status_value[ssp_pkg::ST_DETECT_B_POS] = !detect_b_n_s;
		status_value[ssp_pkg::ST_DETECT_A_POS] = !detect_a_n_s;
		status_value[ssp_pkg::ST_BATTERY_TWO_POS] = battery_two_s;
		status_value[ssp_pkg::ST_BATTERY_ONE_POS] = battery_one_s;

		ident_value = {ssp_pkg::IDENT_TYPE_VALUE, state_q.ident_rsvd, state_q.compat_revision_field};

		ctrl_raw = 8'h00;
		ctrl_raw[ssp_pkg::PC_GATE_POS] = state_q.card_output_gate;
		ctrl_raw[ssp_pkg::PC_AUTO_POS] = state_q.auto_power_switch_on;
		ctrl_raw[ssp_pkg::PC_VCC_HI_POS] = state_q.ctrl_bit4;
		ctrl_raw[ssp_pkg::PC_VCC_LO_POS] = state_q.ctrl_bit3;
		ctrl_raw[ssp_pkg::PC_VPP_POS +: 2] = state_q.program_voltage_request;
		if (layout_a) begin
			ctrl_value = ctrl_raw & ssp_pkg::PC_MASK_LAYOUT_A;
		end else begin
			ctrl_value = ctrl_raw & ssp_pkg::PC_MASK_LAYOUT_B;
		end
	end

	// ****************************************
	// next state
	// ****************************************
	logic [7:0] wr_mask;
	logic [7:0] ctrl_next;

	always_comb begin
		state_d = state_q;
		wr_mask = layout_a ? ssp_pkg::PC_MASK_LAYOUT_A : ssp_pkg::PC_MASK_LAYOUT_B;
		ctrl_next = (ctrl_raw & ~wr_mask) | (wdata_i & wr_mask);

		// read data stands only in the cycle after the strobe
		state_d.rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				ssp_pkg::OFF_IDENT: state_d.rdata = ident_value;
				ssp_pkg::OFF_SOCKET_INTERFACE_STATUS: state_d.rdata = status_value;
				ssp_pkg::OFF_SOCKET_POWER_CONTROL: state_d.rdata = ctrl_value;
				default: state_d.rdata = 8'h00;
			endcase
		end

		// writes; the status register takes none
		if (wr_i) begin
			case (addr_i)
				ssp_pkg::OFF_IDENT: begin
					state_d.ident_rsvd = wdata_i[ssp_pkg::IDENT_RSVD_POS +: 2];
					state_d.compat_revision_field = wdata_i[3:0];
				end
				ssp_pkg::OFF_SOCKET_POWER_CONTROL: begin
					state_d.card_output_gate = ctrl_next[ssp_pkg::PC_GATE_POS];
					state_d.auto_power_switch_on = ctrl_next[ssp_pkg::PC_AUTO_POS];
					state_d.ctrl_bit4 = ctrl_next[ssp_pkg::PC_VCC_HI_POS];
					state_d.ctrl_bit3 = ctrl_next[ssp_pkg::PC_VCC_LO_POS];
					state_d.program_voltage_request = ctrl_next[ssp_pkg::PC_VPP_POS +: 2];
				end
				default: begin
					state_d.ident_rsvd = state_q.ident_rsvd;
				end
			endcase
		end

		// registered socket outputs
		state_d.out_gate = state_q.card_output_gate;
		state_d.out_supply = supply_on;
		state_d.out_3v = supply_3v;
		state_d.out_vpp = vpp_now;
		state_d.out_power = supply_on;
		state_d.out_layout_a = layout_a;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q.rdata <= 8'h00;
			state_q.ident_rsvd <= ssp_pkg::IDENT_RSVD_RESET;
			state_q.compat_revision_field <= ssp_pkg::COMPAT_REV_RESET;
			state_q.card_output_gate <= ssp_pkg::PC_RESET[ssp_pkg::PC_GATE_POS];
			state_q.auto_power_switch_on <= ssp_pkg::PC_RESET[ssp_pkg::PC_AUTO_POS];
			state_q.ctrl_bit4 <= ssp_pkg::PC_RESET[ssp_pkg::PC_VCC_HI_POS];
			state_q.ctrl_bit3 <= ssp_pkg::PC_RESET[ssp_pkg::PC_VCC_LO_POS];
			state_q.program_voltage_request <= ssp_pkg::PC_RESET[1:0];
			state_q.out_gate <= 1'b0;
			state_q.out_supply <= 1'b0;
			state_q.out_3v <= 1'b0;
			state_q.out_vpp <= ssp_pkg::VPP_NONE;
			state_q.out_power <= 1'b0;
			state_q.out_layout_a <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rdata_o = state_q.rdata;
	assign card_output_gate_o = state_q.out_gate;
	assign socket_supply_on_o = state_q.out_supply;
	assign supply_3v_sel_o = state_q.out_3v;
	assign program_voltage_o = state_q.out_vpp;
	assign socket_power_on_flag_o = state_q.out_power;
	assign layout_a_o = state_q.out_layout_a;

endmodule

// ### ssp_socket_regs_asserts.sv
// assertion checker for the socket status and power control registers
module ssp_socket_regs_chk (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic card_ready_i,
	input wire logic write_protect_i,
	input wire logic detect_pin_a_n_i,
	input wire logic detect_pin_b_n_i,
	input wire logic battery_pin_one_i,
	input wire logic battery_pin_two_i,
	input wire logic card_output_gate_o,
	input wire logic socket_supply_on_o,
	input wire logic supply_3v_sel_o,
	input wire logic [1:0] program_voltage_o,
	input wire logic socket_power_on_flag_o,
	input wire logic layout_a_o
);
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	a_status_top: assert property (
		$past(rd_i) && $past(addr_i) == 8'h01 |-> rdata_o[7:6] == {1'b0, $past(socket_power_on_flag_o)})
		else $error("status top bits wrong");
	a_status_pins: assert property (
		$past(rd_i) && $past(addr_i) == 8'h01 |-> rdata_o[5:0] == $past({card_ready_i, write_protect_i,
		!detect_pin_b_n_i, !detect_pin_a_n_i, battery_pin_two_i, battery_pin_one_i}, 3))
		else $error("status pin bits wrong");
	a_flag_supply: assert property (socket_power_on_flag_o == socket_supply_on_o)
		else $error("power flag differs from supply");
	a_vpp_gated: assert property (!socket_supply_on_o |-> program_voltage_o == 2'h0)
		else $error("programming voltage without supply");
	a_vpp_code: assert property (program_voltage_o != 2'h3)
		else $error("reserved programming voltage driven");
	a_three_volt: assert property (supply_3v_sel_o |-> socket_supply_on_o)
		else $error("3 V chosen with supply off");
	a_ctrl_reserved: assert property (
		$past(rd_i) && $past(addr_i) == 8'h02 |-> (rdata_o & ~(layout_a_o ? 8'hB3 : 8'h9B)) == 8'h00)
		else $error("reserved control bit set");
	a_gate_read: assert property (
		$past(rd_i) && $past(addr_i) == 8'h02 |-> rdata_o[7] == card_output_gate_o)
		else $error("output gate differs from control bit");
	a_reset_off: assert property (
		$rose(reset_n_i) |-> !card_output_gate_o && !socket_supply_on_o && program_voltage_o == 2'h0)
		else $error("outputs active after reset");
	c_status_read: cover property ($past(rd_i) && $past(addr_i) == 8'h01);
	c_supply_a: cover property (socket_supply_on_o && layout_a_o);
	c_three_volt: cover property (supply_3v_sel_o);
endmodule

bind ssp_socket_regs ssp_socket_regs_chk i_ssp_socket_regs_chk (.*);

// ### testbench.sv
// self-checking bench for the socket status and power control registers
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic seat = 1'b1;
	logic [3:0] misc = 4'h0;
	logic sup = 1'b0;
	logic aut = 1'b0;
	logic [5:0] pins;
	logic [7:0] rdata;
	logic gate, on_o, v3, flag;
	logic [1:0] vpp;
	logic [7:0] exp_q[$];
	logic rd_seen = 1'b0;
	int fail_count = 0;
	int n_checks = 0;
	// ****************************************
	// clock, design and card
	// ****************************************
	always #2 clk = ~clk;
	ssp_socket_regs i_ssp_socket_regs (.clk_i(clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .card_ready_i(pins[5]), .write_protect_i(pins[4]),
		.detect_pin_b_n_i(pins[3]), .detect_pin_a_n_i(pins[2]), .battery_pin_two_i(pins[1]),
		.battery_pin_one_i(pins[0]), .sys_auto_switch_allow_i(aut), .sys_supply_allow_i(sup),
		.card_output_gate_o(gate), .socket_supply_on_o(on_o), .supply_3v_sel_o(v3),
		.program_voltage_o(vpp), .socket_power_on_flag_o(flag), .layout_a_o());
	ssp_card_model i_ssp_card_model (.clk_i(clk), .seat_i(seat), .misc_i(misc), .pins_o(pins));
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd_s <= 1'b0;
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ****************************************
	// read data monitor
	// ****************************************
	always @(posedge clk) begin
		if (rd_seen)
			chk(rdata, exp_q.pop_front());
		rd_seen <= rd_s;
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		logic [7:0] w;
		logic on;
		logic [1:0] vp;
		void'($urandom(64528));
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		rd(8'h00, 8'h84);
		rd(8'h02, 8'h00);
		rd(8'h01, {2'h0, pins ^ 6'h0C});
		wr(8'h01, 8'hFF);
		rd(8'h01, {2'h0, pins ^ 6'h0C});
		wr(8'h3A, 8'hFF);
		rd(8'h3A, 8'h00);
		for (int i = 0; i < 32; i++) begin
			if (i == 16)
				wr(8'h00, 8'h02);
			w = (8'($urandom) & 8'hE4) | {3'h0, i[3:2], 1'h0, i[1:0]};
			{sup, aut, seat, misc} <= 7'($urandom);
			wr(8'h02, w);
			repeat (6) @(posedge clk);
			on = (i < 16) ? w[4] : w[4] & sup & ((w[5] & aut) ? seat : 1'b1);
			vp = (on && w[1:0] != 2'h3) ? w[1:0] : 2'h0;
			chk({1'h0, flag, gate, on_o, v3, vpp}, {1'h0, on, w[7], on, i < 16 && on && w[3], vp});
			rd(8'h01, {1'b0, on, pins ^ 6'h0C});
			rd(8'h02, w & (i < 16 ? 8'h9B : 8'hB3));
		end
		repeat (2) @(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd(8'h00, 8'h84);
		rd(8'h02, 8'h00);
		repeat (4) @(posedge clk);
		conclude();
	end
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
endmodule
